// *** hw/dcp_dev.sv ***
`timescale 1ns/10ps
// Operation
// - type code must match fixed value
// - three address pins match received bits
// - write protect low blocks setting writes
// - data changes only while clock low
// - respond only after a start condition
// - master ends transfers with stop
// - release after eight bits, ninth acknowledges
// - ack address, instruction, then data
// - master clocks, device is slave
// - wiper decoded one-hot to 64 switches
// - opcode, selector, two zero bits
// - seven opcode encodings, selector zero for wiper read, write and step
// - copies finish after instruction byte
// - register read/write uses three bytes
// - clock high, data high steps up
// - clock high, data low steps down
// - stop starts nonvolatile write, inputs disabled
// - busy withholds address acknowledge
// - wiper loads from bus or setting
// - power-up loads wiper from setting zero
// - setting change is nonvolatile write
module dcp_dev import dcp_pkg::*; #(
   parameter int NVW_CYC    = DCP_NVW_CYC,
   parameter int SETTLE_CYC = DCP_SETTLE_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   dcp_if.dev               BUS,
   input  wire logic [2:0]  ADDR_PINS,
   input  wire logic        WP_N,
   output logic [63:0]      SWITCH_SEL,
   output logic [5:0]       WIPER_POS,
   output logic             BUSY
);
   initial begin
      if (NVW_CYC < 1 || SETTLE_CYC < 1)
         $error("dcp_dev: cycle counts must be positive");
   end

   typedef enum logic [6:0] {
      DV_IDLE  = 7'h01,
      DV_ADDR  = 7'h02,
      DV_INSTR = 7'h04,
      DV_DATA  = 7'h08,
      DV_SEND  = 7'h10,
      DV_STEP  = 7'h20,
      DV_SKIP  = 7'h40
   } dcp_dev_st_t;

   // ------------------------------------------------------------
   // synchronisers and edge detection
   // ------------------------------------------------------------
   logic [1:0] scl_s_q, sda_s_q;
   logic       scl_q, sda_q;
   logic [1:0] wp_s_q;
   logic [5:0] pin_s_q;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wp_s_q  <= 2'h3;
         pin_s_q <= 6'h00;
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         wp_s_q  <= {wp_s_q[0], WP_N};
         pin_s_q <= {pin_s_q[2:0], ADDR_PINS};
         scl_s_q <= {scl_s_q[0], BUS.scl};
         sda_s_q <= {sda_s_q[0], BUS.sda};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end
   wire scl_r   = scl_s_q[1] && !scl_q;
   wire scl_f   = !scl_s_q[1] && scl_q;
   wire start_c = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
   wire stop_c  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];

   // ------------------------------------------------------------
   // byte engine
   // ------------------------------------------------------------
   dcp_dev_st_t st_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;
   logic        ack_ph_q;
   logic        ack_drv_q;
   logic        sda_oe_q;
   logic        sda_o_q;
   logic [3:0]  op_q;
   logic [1:0]  sel_q;
   logic        nvw_pend_q;
   logic [5:0]  nvw_val_q;
   logic        busy_q;
   logic [31:0] nvw_cnt_q;
   logic [5:0]  set_q [DCP_NUM_SET];
   logic [5:0]  wip_q;
   logic        init_q;
   logic        settle_pend_q;
   logic [15:0] settle_cnt_q;
   logic [5:0]  settle_val_q;

   wire [7:0] byte_in = {sh_q[6:0], sda_q};
   // decided at the ack phase, when sh_q holds the whole byte
   wire [2:0] pins    = pin_s_q[5:3];
   wire       addr_ok = sh_q[7:4] == DCP_TYPE_CODE
                     && sh_q[3] == pins[2]
                     && sh_q[2] == pins[1]
                     && sh_q[0] == pins[0];
   function automatic logic instr_ok(input logic [7:0] b);
      logic [3:0] o;
      o = b[7:4];
      if (b[1:0] != 2'h0)
         return 1'b0;
      if (o == DCP_OP_RD_WIPER || o == DCP_OP_WR_WIPER
          || o == DCP_OP_STEP)
         return b[3:2] == 2'h0;
      return o == DCP_OP_RD_SET || o == DCP_OP_WR_SET
          || o == DCP_OP_SET2WIP || o == DCP_OP_WIP2SET;
   endfunction

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_q       <= DV_IDLE;
         bit_q      <= 4'h0;
         sh_q       <= 8'h00;
         ack_ph_q   <= 1'b0;
         ack_drv_q  <= 1'b0;
         op_q       <= 4'h0;
         sel_q      <= 2'h0;
         nvw_pend_q <= 1'b0;
         nvw_val_q  <= 6'h00;
      end else if (start_c) begin
         st_q     <= DV_ADDR;
         bit_q    <= 4'h0;
         ack_ph_q <= 1'b0;
         ack_drv_q <= 1'b0;
      end else if (stop_c) begin
         st_q      <= DV_IDLE;
         ack_drv_q <= 1'b0;
      end else if (st_q != DV_IDLE && st_q != DV_SKIP) begin
         if (st_q == DV_STEP) begin
            // steps handled in wiper process
         end else if (scl_r && !ack_ph_q && st_q != DV_SEND) begin
            sh_q  <= byte_in;
            bit_q <= bit_q + 4'h1;
         end else if (scl_r && !ack_ph_q) begin
            bit_q <= bit_q + 4'h1;
         end else if (scl_f && !ack_ph_q && bit_q == 4'h8) begin
            ack_ph_q <= 1'b1;
            if (st_q == DV_ADDR)
               ack_drv_q <= addr_ok && !sh_q[1] && !busy_q;
            else if (st_q == DV_INSTR)
               ack_drv_q <= instr_ok(sh_q);
            else if (st_q == DV_DATA)
               ack_drv_q <= 1'b1;
            else
               ack_drv_q <= 1'b0;
         end else if (scl_f && ack_ph_q) begin
            ack_ph_q  <= 1'b0;
            ack_drv_q <= 1'b0;
            bit_q     <= 4'h0;
            if (!ack_drv_q)
               st_q <= DV_SKIP;
            else if (st_q == DV_ADDR)
               st_q <= DV_INSTR;
            else if (st_q == DV_INSTR) begin
               op_q  <= sh_q[7:4];
               sel_q <= sh_q[3:2];
               case (sh_q[7:4])
                  DCP_OP_RD_WIPER, DCP_OP_RD_SET: st_q <= DV_SEND;
                  DCP_OP_WR_WIPER, DCP_OP_WR_SET: st_q <= DV_DATA;
                  DCP_OP_STEP:    st_q <= DV_STEP;
                  DCP_OP_WIP2SET: begin
                     nvw_pend_q <= wp_s_q[1];
                     nvw_val_q  <= wip_q;
                     st_q       <= DV_SKIP;
                  end
                  default:        st_q <= DV_SKIP;
               endcase
            end else if (st_q == DV_DATA) begin
               if (op_q == DCP_OP_WR_SET) begin
                  nvw_pend_q <= wp_s_q[1];
                  nvw_val_q  <= sh_q[5:0];
               end
               st_q <= DV_SKIP;
            end else
               st_q <= DV_SKIP;
         end
      end
      if (RST_N && nvw_pend_q && stop_c)
         nvw_pend_q <= 1'b0;
   end

   // read data shifted out msb first; master ack ignored
   wire [7:0] rd_byte = (op_q == DCP_OP_RD_SET) ? {2'h0, set_q[sel_q]}
                                                : {2'h0, wip_q};
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sda_oe_q <= 1'b0;
         sda_o_q  <= 1'b1;
      end else if (ack_drv_q) begin
         sda_oe_q <= 1'b1;
         sda_o_q  <= 1'b0;
      end else if (st_q == DV_SEND && bit_q < 4'h8 && !ack_ph_q
                   && !scl_s_q[1]) begin
         sda_oe_q <= 1'b1;
         sda_o_q  <= rd_byte[3'(7 - bit_q)];
      end else if (!scl_s_q[1] || st_q == DV_IDLE) begin
         sda_oe_q <= 1'b0;
         sda_o_q  <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // nonvolatile write timer
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         busy_q    <= 1'b0;
         nvw_cnt_q <= 32'h0;
      end else if (nvw_pend_q && stop_c) begin
         busy_q    <= 1'b1;
         nvw_cnt_q <= 32'(NVW_CYC - 1);
      end else if (busy_q) begin
         if (nvw_cnt_q == 32'h0)
            busy_q <= 1'b0;
         else
            nvw_cnt_q <= nvw_cnt_q - 32'h1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < DCP_NUM_SET; i++)
            set_q[i] <= DCP_SET_RST;
      end else if (busy_q && nvw_cnt_q == 32'h0) begin
         set_q[sel_q] <= nvw_val_q;
      end
   end

   // ------------------------------------------------------------
   // wiper register
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wip_q         <= 6'h00;
         init_q        <= 1'b1;
         settle_pend_q <= 1'b0;
         settle_cnt_q  <= 16'h0;
         settle_val_q  <= 6'h00;
      end else if (init_q) begin
         init_q <= 1'b0;
         wip_q  <= set_q[0];
      end else if (settle_pend_q) begin
         if (settle_cnt_q == 16'h0) begin
            settle_pend_q <= 1'b0;
            wip_q         <= settle_val_q;
         end else
            settle_cnt_q <= settle_cnt_q - 16'h1;
      end else if (st_q == DV_INSTR && ack_ph_q && scl_f && ack_drv_q
                   && sh_q[7:4] == DCP_OP_SET2WIP) begin
         settle_pend_q <= 1'b1;
         settle_cnt_q  <= 16'(SETTLE_CYC - 1);
         settle_val_q  <= set_q[sh_q[3:2]];
      end else if (st_q == DV_DATA && ack_ph_q && scl_f
                   && op_q == DCP_OP_WR_WIPER) begin
         wip_q <= sh_q[5:0];
      end else if (st_q == DV_STEP && scl_r) begin
         if (sda_s_q[1] && wip_q != 6'h3F)
            wip_q <= wip_q + 6'h01;
         else if (!sda_s_q[1] && wip_q != 6'h00)
            wip_q <= wip_q - 6'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SWITCH_SEL <= 64'h1;
         WIPER_POS  <= 6'h00;
         BUSY       <= 1'b0;
      end else begin
         SWITCH_SEL <= 64'h1 << wip_q;
         WIPER_POS  <= wip_q;
         BUSY       <= busy_q;
      end
   end

   assign BUS.sda_dev_o  = sda_o_q;
   assign BUS.sda_dev_oe = sda_oe_q;
endmodule

// *** hw/dcp_host.sv ***
`timescale 1ns/10ps
module dcp_host import dcp_pkg::*; #(
   parameter int DIV = DCP_HOST_DIV
) (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   dcp_if.host             BUS,
   input  wire logic       GO,
   input  wire logic [7:0] ADDR_BYTE,
   input  wire logic [7:0] INSTR_BYTE,
   input  wire logic [7:0] DATA_BYTE,
   input  wire logic [1:0] NBYTES,
   input  wire logic       RD,
   output logic            DONE,
   output logic            ACK_OK,
   output logic [7:0]      RD_DATA,
   output logic            BUSY
);
   initial begin
      if (DIV < 2)
         $error("dcp_host: DIV must be at least 2");
   end
   typedef enum logic [4:0] {
      HS_IDLE  = 5'h01,
      HS_START = 5'h02,
      HS_BIT   = 5'h04,
      HS_STOP  = 5'h08,
      HS_END   = 5'h10
   } dcp_host_st_t;

   dcp_host_st_t st_q;
   logic [15:0]  div_q;
   logic [1:0]   ph_q;
   logic [3:0]   bit_q;
   logic [1:0]   byte_q;
   logic [1:0]   n_q;
   logic         rd_q, acks_q;
   logic [7:0]   tx_q [3];
   logic [7:0]   rx_q;
   logic         scl_q, sdo_q, sdoe_q;
   logic [1:0]   sda_s_q;
   wire          tick = div_q == 16'(DIV - 1);
   wire          rd_byte = rd_q && byte_q == 2'h2;

   always_ff @(posedge CLK) begin
      if (!RST_N)
         sda_s_q <= 2'h3;
      else
         sda_s_q <= {sda_s_q[0], BUS.sda};
   end

   // ------------------------------------------------------------
   // bit sequencer: four phases per bit, data set while scl low
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_q <= HS_IDLE; div_q <= 16'h0; ph_q <= 2'h0;
         bit_q <= 4'h0; byte_q <= 2'h0; n_q <= 2'h0; rd_q <= 1'b0;
         acks_q <= 1'b1; rx_q <= 8'h00; scl_q <= 1'b1;
         sdo_q <= 1'b1; sdoe_q <= 1'b0;
         DONE <= 1'b0; ACK_OK <= 1'b0; RD_DATA <= 8'h00; BUSY <= 1'b0;
         for (int i = 0; i < 3; i++) tx_q[i] <= 8'h00;
      end else begin
         DONE <= 1'b0;
         div_q <= tick ? 16'h0 : div_q + 16'h1;
         case (st_q)
            HS_IDLE: if (GO) begin
               tx_q[0] <= ADDR_BYTE; tx_q[1] <= INSTR_BYTE;
               tx_q[2] <= DATA_BYTE; n_q <= NBYTES; rd_q <= RD;
               acks_q <= 1'b1; byte_q <= 2'h0; bit_q <= 4'h0;
               ph_q <= 2'h0; BUSY <= 1'b1; st_q <= HS_START;
            end
            HS_START: if (tick) begin
               sdoe_q <= 1'b1; sdo_q <= 1'b0; st_q <= HS_BIT;
            end
            HS_BIT: if (tick) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  2'h0: begin
                     scl_q <= 1'b0;
                  end
                  2'h1: begin
                     if (bit_q < 4'h8 && !rd_byte) begin
                        sdoe_q <= 1'b1;
                        sdo_q  <= tx_q[byte_q][3'(7 - bit_q)];
                     end else if (bit_q == 4'h8 && rd_byte) begin
                        sdoe_q <= 1'b1; sdo_q <= 1'b1; // final nack
                     end else begin
                        sdoe_q <= 1'b0; sdo_q <= 1'b1;
                     end
                  end
                  2'h2: begin
                     scl_q <= 1'b1;
                  end
                  default: begin
                     if (bit_q < 4'h8)
                        rx_q <= {rx_q[6:0], sda_s_q[1]};
                     else if (!rd_byte && sda_s_q[1])
                        acks_q <= 1'b0;
                     if (bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (byte_q == n_q || (!rd_byte && sda_s_q[1]))
                           st_q <= HS_STOP;
                        else
                           byte_q <= byte_q + 2'h1;
                     end else
                        bit_q <= bit_q + 4'h1;
                  end
               endcase
            end
            HS_STOP: if (tick) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  2'h0: scl_q <= 1'b0;
                  2'h1: begin sdoe_q <= 1'b1; sdo_q <= 1'b0; end
                  2'h2: scl_q <= 1'b1;
                  default: begin
                     sdoe_q <= 1'b0; sdo_q <= 1'b1; st_q <= HS_END;
                  end
               endcase
            end
            default: begin
               DONE <= 1'b1; ACK_OK <= acks_q; RD_DATA <= rx_q;
               BUSY <= 1'b0; st_q <= HS_IDLE;
            end
         endcase
      end
   end

   assign BUS.scl         = scl_q;
   assign BUS.sda_host_o  = sdo_q;
   assign BUS.sda_host_oe = sdoe_q;
endmodule

// *** hw/dcp_if.sv ***
`timescale 1ns/10ps
interface dcp_if;
   logic scl;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;
   // open drain with pull-up
   assign sda = !((sda_host_oe && !sda_host_o) ||
                  (sda_dev_oe && !sda_dev_o));
   modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (output scl, input sda, output sda_host_o,
                 output sda_host_oe);
endinterface

// *** hw/dcp_pkg.sv ***
package dcp_pkg;
   // ------------------------------------------------------------
   // bus framing
   // ------------------------------------------------------------
   // type code value is arbitrary
   localparam logic [3:0] DCP_TYPE_CODE   = 4'h6;
   localparam int         DCP_BITS_BYTE   = 8;
   localparam int         DCP_POS_W       = 6;
   localparam int         DCP_NUM_SET     = 4;
   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [3:0] DCP_OP_RD_WIPER = 4'h9;
   localparam logic [3:0] DCP_OP_WR_WIPER = 4'hA;
   localparam logic [3:0] DCP_OP_RD_SET   = 4'hB;
   localparam logic [3:0] DCP_OP_WR_SET   = 4'hC;
   localparam logic [3:0] DCP_OP_SET2WIP  = 4'hD;
   localparam logic [3:0] DCP_OP_WIP2SET  = 4'hE;
   localparam logic [3:0] DCP_OP_STEP     = 4'h2;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int DCP_CLK_NS         = 10;
   localparam int DCP_NVW_TIME_US    = 5000;
   localparam int DCP_NVW_CYC        = DCP_NVW_TIME_US * 1000 / DCP_CLK_NS;
   localparam int DCP_SETTLE_NS      = 100;
   localparam int DCP_SETTLE_CYC     = DCP_SETTLE_NS / DCP_CLK_NS;
   localparam int DCP_HOST_DIV       = 4;
   localparam logic [5:0] DCP_SET_RST = 6'h00;
endpackage

// *** tb/dcp_sva.sv ***
`timescale 1ns/10ps
module dcp_sva import dcp_pkg::*; (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe
);
   // -------------------------------------------------------------
   // frame tracking
   // -------------------------------------------------------------
   logic       scl_q, sda_q, in_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic [7:0] sh_q;
   logic       start_w, stop_w, rise_w, dev_pull, host_pull, ninth;

   assign start_w   = scl && scl_q && sda_q && !sda;
   assign stop_w    = scl && scl_q && !sda_q && sda;
   assign rise_w    = scl && !scl_q;
   assign dev_pull  = sda_dev_oe && !sda_dev_o;
   assign host_pull = sda_host_oe && !sda_host_o;
   assign ninth     = rise_w && bit_q == 4'h8;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || stop_w)
         in_q <= 1'h0;
      else if (start_w)
         in_q <= 1'h1;
   end

   // ack bit is not shifted, so sh_q holds the whole byte at the ninth
   always_ff @(posedge CLK) begin
      if (!RST_N || start_w) begin
         bit_q  <= 4'h0;
         byte_q <= 2'h0;
         sh_q   <= 8'h00;
      end else if (rise_w) begin
         bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         if (bit_q == 4'h8 && byte_q != 2'h3)
            byte_q <= byte_q + 2'h1;
         if (bit_q != 4'h8)
            sh_q <= {sh_q[6:0], sda};
      end
   end

   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_dev_edge;
      $changed(dev_pull) |-> !scl;
   endproperty
   a_dev_edge: assert property (p_dev_edge)
      else $error("device moved data line with clock high");
   property p_ack_held;
      rise_w && dev_pull |-> dev_pull [*6];
   endproperty
   a_ack_held: assert property (p_ack_held)
      else $error("device pull not held through clock high");
   property p_in_frame;
      dev_pull |-> in_q;
   endproperty
   a_in_frame: assert property (p_in_frame)
      else $error("device pulled data line outside a frame");
   property p_bit_pos;
      rise_w && dev_pull && byte_q != 2'h2 |-> bit_q == 4'h8;
   endproperty
   a_bit_pos: assert property (p_bit_pos)
      else $error("device pulled outside the ack bit");
   property p_type_nack;
      ninth && byte_q == 2'h0 && sh_q[7:4] != DCP_TYPE_CODE |-> !dev_pull;
   endproperty
   a_type_nack: assert property (p_type_nack)
      else $error("device acked a foreign type code");
   property p_low_nack;
      ninth && byte_q == 2'h1 && sh_q[1:0] != 2'h0 |-> !dev_pull;
   endproperty
   a_low_nack: assert property (p_low_nack)
      else $error("device acked instruction with low bits set");
   property p_op_nack;
      ninth && byte_q == 2'h1 && !(sh_q[7:4] inside {4'h9, 4'hA, 4'hB,
         4'hC, 4'hD, 4'hE, 4'h2}) |-> !dev_pull;
   endproperty
   a_op_nack: assert property (p_op_nack)
      else $error("device acked an unknown opcode");
   property p_frame_stop;
      start_w |-> ##[1:1000] stop_w;
   endproperty
   a_frame_stop: assert property (p_frame_stop)
      else $error("frame not closed by a stop");
   property p_host_rel;
      ninth && byte_q != 2'h2 |-> !host_pull;
   endproperty
   a_host_rel: assert property (p_host_rel)
      else $error("host held data line during ack bit");
endmodule

// *** tb/test_pot_two_wire_command_slave.sv ***
`timescale 1ns/10ps
module test_pot_two_wire_command_slave import dcp_pkg::*;;
   // short write time keeps ack polling inside the run
   localparam int NVW = 400;
   localparam int SET = 4;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] i;
      logic [7:0] d;
      logic [1:0] nb;
      logic       rd;
      logic       wp;
      logic       ack;
      logic [5:0] rv;
      logic [5:0] wip;
   } dcp_row_t;
   // -------------------------------------------------------------
   // address, instr, data, bytes, read, wp, ack, read value, wiper
   // -------------------------------------------------------------
   localparam dcp_row_t ROWS [18] = '{
      '{8'h69,8'hA0,8'h2A,2'h2,1'h0,1'h1,1'h1,6'h00,6'h2A},
      '{8'h69,8'h90,8'h00,2'h2,1'h1,1'h1,1'h1,6'h2A,6'h2A},
      '{8'h69,8'hC8,8'h15,2'h2,1'h0,1'h1,1'h1,6'h00,6'h2A},
      '{8'h69,8'hB8,8'h00,2'h2,1'h1,1'h1,1'h1,6'h15,6'h2A},
      '{8'h69,8'hD8,8'h00,2'h1,1'h0,1'h1,1'h1,6'h00,6'h15},
      '{8'h69,8'hA0,8'h3F,2'h2,1'h0,1'h1,1'h1,6'h00,6'h3F},
      '{8'h69,8'hE4,8'h00,2'h1,1'h0,1'h1,1'h1,6'h00,6'h3F},
      '{8'h69,8'hB4,8'h00,2'h2,1'h1,1'h1,1'h1,6'h3F,6'h3F},
      '{8'h69,8'hCC,8'h11,2'h2,1'h0,1'h0,1'h1,6'h00,6'h3F},
      '{8'h69,8'hBC,8'h00,2'h2,1'h1,1'h1,1'h1,6'h00,6'h3F},
      '{8'h79,8'h00,8'h00,2'h0,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h61,8'h00,8'h00,2'h0,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h6D,8'h00,8'h00,2'h0,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h68,8'h00,8'h00,2'h0,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h6B,8'h00,8'h00,2'h0,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h69,8'hA1,8'h00,2'h2,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h69,8'hF0,8'h00,2'h2,1'h0,1'h1,1'h0,6'h00,6'h3F},
      '{8'h69,8'hD0,8'h00,2'h1,1'h0,1'h1,1'h1,6'h00,6'h00}};
   // start wiper, step byte, expected wiper with lsb dropped
   localparam logic [7:0] STEPS [3][3] = '{
      '{8'h3E, 8'hFF, 8'h1F},
      '{8'h10, 8'hFF, 8'h0C},
      '{8'h05, 8'h00, 8'h00}};

   logic        CLK = 1'h0, RST_N = 1'h0, go = 1'h0, rd = 1'h0;
   logic        wp_n = 1'h1, done, ack_ok, d_busy, h_busy;
   logic [7:0]  ab = 8'h00, ib = 8'h00, db = 8'h00, rdata;
   logic [1:0]  nb = 2'h0;
   logic [63:0] sel;
   logic [5:0]  wip;
   int          mismatches = 0, num_checks = 0, cyc = 0, n;

   dcp_if dcp_if_inst ();
   dcp_dev #(.NVW_CYC(NVW), .SETTLE_CYC(SET)) dcp_dev_inst (
      .CLK(CLK), .RST_N(RST_N), .BUS(dcp_if_inst.dev), .ADDR_PINS(3'h5),
      .WP_N(wp_n), .SWITCH_SEL(sel), .WIPER_POS(wip), .BUSY(d_busy));
   dcp_host dcp_host_inst (
      .CLK(CLK), .RST_N(RST_N), .BUS(dcp_if_inst.host), .GO(go),
      .ADDR_BYTE(ab), .INSTR_BYTE(ib), .DATA_BYTE(db), .NBYTES(nb),
      .RD(rd), .DONE(done), .ACK_OK(ack_ok), .RD_DATA(rdata),
      .BUSY(h_busy));
   dcp_sva dcp_sva_inst (
      .CLK(CLK), .RST_N(RST_N), .scl(dcp_if_inst.scl),
      .sda(dcp_if_inst.sda), .sda_host_o(dcp_if_inst.sda_host_o),
      .sda_host_oe(dcp_if_inst.sda_host_oe),
      .sda_dev_o(dcp_if_inst.sda_dev_o),
      .sda_dev_oe(dcp_if_inst.sda_dev_oe));

   always #5 CLK = !CLK;

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic frame(input logic [7:0] a, i, d, input logic [1:0] b,
                        input logic r, w);
      @(posedge CLK);
      ab <= a;
      ib <= i;
      db <= d;
      nb <= b;
      rd <= r;
      wp_n <= w;
      go <= 1'h1;
      @(posedge CLK);
      go <= 1'h0;
      n = 0;
      do begin
         @(negedge CLK);
         n++;
      end while (done !== 1'h1 && n < 2000);
      if (n >= 2000)
         mismatches++;
   endtask

   // settle delay, then wait out any nonvolatile write
   task automatic quiet();
      repeat (SET + 4) @(posedge CLK);
      n = 0;
      while (d_busy !== 1'h0 && n < 1000) begin
         @(posedge CLK);
         n++;
      end
      if (n >= 1000)
         mismatches++;
      @(negedge CLK);
   endtask

   initial begin
      repeat (10) @(posedge CLK);
      RST_N <= 1'h1;
      repeat (2) @(negedge CLK);
      chk("wiper", wip, 64'(DCP_SET_RST));
      chk("sel", sel, 64'h1);
      foreach (ROWS[k]) begin
         frame(ROWS[k].a, ROWS[k].i, ROWS[k].d, ROWS[k].nb, ROWS[k].rd,
               ROWS[k].wp);
         quiet();
         chk("ack", ack_ok, ROWS[k].ack);
         chk("hbusy", h_busy, 1'h0);
         if (ROWS[k].rd)
            chk("rdata", rdata, {2'h0, ROWS[k].rv});
         chk("wiper", wip, ROWS[k].wip);
         chk("sel", sel, 64'h1 << ROWS[k].wip);
      end
      // ack polling while the setting write runs
      frame(8'h69, 8'hC4, 8'h2B, 2'h2, 1'h0, 1'h1);
      repeat (4) @(negedge CLK);
      chk("busy", d_busy, 1'h1);
      frame(8'h69, 8'h00, 8'h00, 2'h0, 1'h0, 1'h1);
      chk("poll", ack_ok, 1'h0);
      quiet();
      frame(8'h69, 8'h00, 8'h00, 2'h0, 1'h0, 1'h1);
      chk("poll", ack_ok, 1'h1);
      // stepping, counted and pinned at both ends
      foreach (STEPS[k]) begin
         frame(8'h69, 8'hA0, STEPS[k][0], 2'h2, 1'h0, 1'h1);
         frame(8'h69, 8'h20, STEPS[k][1], 2'h2, 1'h0, 1'h1);
         quiet();
         chk("step", wip[5:1], STEPS[k][2]);
      end
      // reset in mid-run reloads setting zero
      @(posedge CLK);
      RST_N <= 1'h0;
      repeat (3) @(posedge CLK);
      RST_N <= 1'h1;
      repeat (2) @(negedge CLK);
      chk("wiper", wip, 64'(DCP_SET_RST));
      wrap_up();
   end
endmodule
